// >>> design/rtcar_top.sv
// alarm, repeat counter, alarm pulse and calibration auto-adjust with axi4-lite registers
//
// How it works
// [R1] software writes calibration outside quarter-minute seconds
// [R2] auto-adjust applied every 15 seconds
// [R3] alarm interval half second up to year
// [R4] alarm fires only while enable bit set
// [R5] software writes compare value while disabled
// [R6] four-bit mask picks digits that must match
// [R7] repeat counter zero, no endless_repeat_flag: single alarm
// [R8] counter FFh gives 255 further repetitions
// [R9] counter decrements after every alarm event
// [R10] counter at zero: last alarm, enable cleared
// [R11] endless_repeat_flag set: counter wraps zero to FFh
// [R12] interrupt request on every alarm event
// [R13] alarm pulse at half the alarm rate
// [R14] software changes times only while disabled
// [R15] software changes config while sync status low
// [R16] calibration times four added to timer
// [R17] pulse toggles per event, low after reset
// [R18] match checked once per digit update
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rtcar_top
    import rtcar_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              cen,
    input  wire logic              digitUpdate,
    input  wire logic              timerOn,
    input  wire logic              clockSyncStatus,
    input  wire logic              curHalfSec,
    input  wire logic [7:0]        curSeconds,
    input  wire logic [7:0]        curMinutes,
    input  wire logic [7:0]        curHours,
    input  wire logic [2:0]        curWeekday,
    input  wire logic [7:0]        curDay,
    input  wire logic [7:0]        curMonth,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   alarmIrq,
    output logic                   alarmPulse,
    output logic                   calAdjustValid,
    output logic [9:0]             calAdjustAmount
);
    typedef enum logic [2:0] {
        REG_CAL, REG_CFG, REG_TIME, REG_DATE, REG_STATUS, REG_NONE
    } rtcar_reg_e;

    // decode shared by the write and read paths
    function automatic rtcar_reg_e decodeReg(input logic [ADDR_W-1:0] addr);
        logic [7:0] word;
        word = {addr[ADDR_W-1:2], 2'b00};
        case (word)
            OFF_CLOCK_CAL:  decodeReg = REG_CAL;
            OFF_ALARM_CFG:  decodeReg = REG_CFG;
            OFF_ALARM_TIME: decodeReg = REG_TIME;
            OFF_ALARM_DATE: decodeReg = REG_DATE;
            OFF_STATUS:     decodeReg = REG_STATUS;
            default:        decodeReg = REG_NONE;
        endcase
    endfunction

    function automatic logic isQuarter(input logic [7:0] sec);
        isQuarter = (sec == SEC_Q0) || (sec == SEC_Q1) || (sec == SEC_Q2) || (sec == SEC_Q3);
    endfunction

    function automatic logic [DATA_W-1:0] mergeStrb(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] data,
                                                    input logic [3:0]        strb);
        logic [DATA_W-1:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        mergeStrb = res;
    endfunction

    logic                    awReady_r;
    logic                    awHeld_r;
    logic [ADDR_W-1:0]       awAddr_r;
    logic                    wReady_r;
    logic                    wHeld_r;
    logic [DATA_W-1:0]       wData_r;
    logic [3:0]              wStrb_r;
    logic                    bValid_r;
    logic [1:0]              bResp_r;
    logic                    arReady_r;
    logic                    rValid_r;
    logic [DATA_W-1:0]       rData_r;
    logic [1:0]              rResp_r;

    logic                    enable_r;
    logic                    endless_repeat_flag_r;
    logic [3:0]              mask_r;
    logic [7:0]              rpt_r;
    logic [7:0]              cal_r;
    logic [7:0]              almSec_r;
    logic [7:0]              almMin_r;
    logic [7:0]              almHour_r;
    logic [2:0]              almWday_r;
    logic [7:0]              almDay_r;
    logic [7:0]              almMonth_r;
    logic [ST_NUM_FLAGS-1:0] flags_r;
    logic                    alarmIrq_r;
    logic                    alarmPulse_r;
    logic                    calValid_r;
    logic [9:0]              calAmount_r;

    rtcar_reg_e              wrReg;
    rtcar_reg_e              rdReg;
    logic                    wrDo;
    logic [DATA_W-1:0]       wrOld;
    logic [DATA_W-1:0]       wrVal;
    logic                    wrCal;
    logic                    wrCfg;
    logic                    wrCmp;
    logic                    wrStatus;
    logic [DATA_W-1:0]       rdMux;
    logic [DATA_W-1:0]       cfgWord;
    logic [DATA_W-1:0]       statusWord;
    logic                    match;
    logic                    evFire;
    logic                    calFire;
    logic [ST_NUM_FLAGS-1:0] flagSet;
    logic [ST_NUM_FLAGS-1:0] flagClr;

    assign wrReg    = decodeReg(awAddr_r);
    assign rdReg    = decodeReg(s_axi_araddr);
    assign wrDo     = cen && awHeld_r && wHeld_r && !bValid_r;
    assign wrVal    = mergeStrb(wrOld, wData_r, wStrb_r);
    assign wrCal    = wrDo && (wrReg == REG_CAL);
    assign wrCfg    = wrDo && (wrReg == REG_CFG);
    assign wrCmp    = wrDo && ((wrReg == REG_TIME) || (wrReg == REG_DATE));
    assign wrStatus = wrDo && (wrReg == REG_STATUS);

    assign cfgWord    = {16'h0000, enable_r, endless_repeat_flag_r, mask_r, 2'b00, rpt_r};
    assign statusWord = {8'h00, rpt_r, 4'h0, timerOn, clockSyncStatus, alarmPulse_r, enable_r,
                         {(8 - ST_NUM_FLAGS){1'b0}}, flags_r};

    always_comb begin
        case (wrReg)
            REG_CAL:  wrOld = {24'h000000, cal_r};
            REG_CFG:  wrOld = cfgWord;
            REG_TIME: wrOld = {8'h00, almHour_r, almMin_r, almSec_r};
            REG_DATE: wrOld = {8'h00, almMonth_r, almDay_r, 5'h00, almWday_r};
            default:  wrOld = '0;
        endcase
    end

    always_comb begin
        case (rdReg)
            REG_CAL:    rdMux = {24'h000000, cal_r};
            REG_CFG:    rdMux = cfgWord;
            REG_TIME:   rdMux = {8'h00, almHour_r, almMin_r, almSec_r};
            REG_DATE:   rdMux = {8'h00, almMonth_r, almDay_r, 5'h00, almWday_r};
            REG_STATUS: rdMux = statusWord;
            default:    rdMux = '0;
        endcase
    end

    // write channel: address and data accepted in either order
    always_ff @(posedge clk) begin
        if (!resetn) begin
            awReady_r <= 1'b1;
            awHeld_r  <= 1'b0;
            awAddr_r  <= '0;
            wReady_r  <= 1'b1;
            wHeld_r   <= 1'b0;
            wData_r   <= '0;
            wStrb_r   <= 4'h0;
            bValid_r  <= 1'b0;
            bResp_r   <= RESP_OKAY;
        end else if (cen) begin
            if (s_axi_awvalid && awReady_r) begin
                awHeld_r  <= 1'b1;
                awAddr_r  <= s_axi_awaddr;
                awReady_r <= 1'b0;
            end
            if (s_axi_wvalid && wReady_r) begin
                wHeld_r  <= 1'b1;
                wData_r  <= s_axi_wdata;
                wStrb_r  <= s_axi_wstrb;
                wReady_r <= 1'b0;
            end
            if (wrDo) begin
                awHeld_r <= 1'b0;
                wHeld_r  <= 1'b0;
                bValid_r <= 1'b1;
                bResp_r  <= (wrReg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            if (bValid_r && s_axi_bready) begin
                bValid_r  <= 1'b0;
                awReady_r <= 1'b1;
                wReady_r  <= 1'b1;
            end
        end
    end

    // read channel: one read outstanding, data sampled at the address handshake
    always_ff @(posedge clk) begin
        if (!resetn) begin
            arReady_r <= 1'b1;
            rValid_r  <= 1'b0;
            rData_r   <= '0;
            rResp_r   <= RESP_OKAY;
        end else if (cen) begin
            if (s_axi_arvalid && arReady_r) begin
                arReady_r <= 1'b0;
                rValid_r  <= 1'b1;
                rData_r   <= rdMux;
                rResp_r   <= (rdReg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (rValid_r && s_axi_rready) begin
                rValid_r  <= 1'b0;
                arReady_r <= 1'b1;
            end
        end
    end

    rtcar_match u_match (
        .mask       (mask_r),
        .curHalfSec (curHalfSec),
        .curSeconds (curSeconds),
        .curMinutes (curMinutes),
        .curHours   (curHours),
        .curWeekday (curWeekday),
        .curDay     (curDay),
        .curMonth   (curMonth),
        .almSeconds (almSec_r),
        .almMinutes (almMin_r),
        .almHours   (almHour_r),
        .almWeekday (almWday_r),
        .almDay     (almDay_r),
        .almMonth   (almMonth_r),
        .match      (match)
    );

    // one look per digit update, so a held match fires once [R18] [R4]
    assign evFire = cen && digitUpdate && enable_r && match;

    // alarm configuration and repeat counter; a software write wins over the event
    always_ff @(posedge clk) begin
        if (!resetn) begin
            enable_r <= 1'b0;
            endless_repeat_flag_r  <= 1'b0;
            mask_r   <= RST_MASK;
            rpt_r    <= RST_RPT;
        end else if (cen) begin
            if (wrCfg) begin
                enable_r <= wrVal[CFG_EN_BIT];
                endless_repeat_flag_r  <= wrVal[CFG_ENDLESS_REPEAT_FLAG_BIT];
                mask_r   <= wrVal[CFG_MASK_HI:CFG_MASK_LO];
                rpt_r    <= wrVal[CFG_RPT_HI:CFG_RPT_LO]; // [R8]
            end else if (evFire) begin
                if (rpt_r != RST_RPT) begin
                    rpt_r <= rpt_r - 8'h01; // [R9]
                end else if (endless_repeat_flag_r) begin
                    rpt_r <= RPT_WRAP; // [R11]
                end else begin
                    enable_r <= 1'b0; // [R7] [R10]
                end
            end
        end
    end

    // alarm compare value and calibration value
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cal_r      <= RST_CAL;
            almSec_r   <= RST_DIGIT;
            almMin_r   <= RST_DIGIT;
            almHour_r  <= RST_DIGIT;
            almWday_r  <= 3'h0;
            almDay_r   <= RST_DIGIT;
            almMonth_r <= RST_DIGIT;
        end else if (cen) begin
            if (wrCal) begin
                cal_r <= wrVal[7:0];
            end
            if (wrDo && (wrReg == REG_TIME)) begin
                almSec_r  <= wrVal[7:0];
                almMin_r  <= wrVal[15:8];
                almHour_r <= wrVal[23:16];
            end
            if (wrDo && (wrReg == REG_DATE)) begin
                almWday_r  <= wrVal[2:0];
                almDay_r   <= wrVal[15:8];
                almMonth_r <= wrVal[23:16];
            end
        end
    end

    // sticky misuse flags: writes that risk a wrong adjust or a false alarm
    assign flagSet[ST_CAL_UNSAFE] = wrCal && timerOn && isQuarter(curSeconds); // [R1]
    assign flagSet[ST_CMP_UNSAFE] = wrCmp && enable_r; // [R5] [R14]
    assign flagSet[ST_CFG_UNSAFE] = wrCfg && clockSyncStatus; // [R15]
    assign flagClr = wrStatus ? wrVal[ST_NUM_FLAGS-1:0] : '0;

    generate
        for (genvar i = 0; i < ST_NUM_FLAGS; i++) begin : g_flag
            // set beats a write-one-to-clear in the same cycle
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    flags_r[i] <= 1'b0;
                end else if (cen) begin
                    flags_r[i] <= flagSet[i] || (flags_r[i] && !flagClr[i]);
                end
            end
        end
    endgenerate

    // interrupt request and half-rate pulse
    always_ff @(posedge clk) begin
        if (!resetn) begin
            alarmIrq_r   <= 1'b0;
            alarmPulse_r <= 1'b0;
        end else if (cen) begin
            alarmIrq_r <= evFire; // [R12]
            if (evFire) begin
                alarmPulse_r <= !alarmPulse_r; // [R13] [R17]
            end
        end
    end

    // adjust request on each quarter-minute second while the timer runs
    assign calFire = cen && digitUpdate && timerOn && !curHalfSec && isQuarter(curSeconds); // [R2]

    always_ff @(posedge clk) begin
        if (!resetn) begin
            calValid_r  <= 1'b0;
            calAmount_r <= 10'h000;
        end else if (cen) begin
            calValid_r <= calFire;
            if (calFire) begin
                calAmount_r <= {cal_r, 2'b00}; // [R16]
            end
        end
    end

    assign s_axi_awready   = awReady_r;
    assign s_axi_wready    = wReady_r;
    assign s_axi_bvalid    = bValid_r;
    assign s_axi_bresp     = bResp_r;
    assign s_axi_arready   = arReady_r;
    assign s_axi_rvalid    = rValid_r;
    assign s_axi_rdata     = rData_r;
    assign s_axi_rresp     = rResp_r;
    assign alarmIrq        = alarmIrq_r;
    assign alarmPulse      = alarmPulse_r;
    assign calAdjustValid  = calValid_r;
    assign calAdjustAmount = calAmount_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_irq_follows_event: assert property (evFire |=> alarmIrq_r) // [R12]
        else $error("alarm event without interrupt");
    chk_pulse_toggles: assert property (evFire |=> alarmPulse_r != $past(alarmPulse_r)) // [R13]
        else $error("alarm pulse did not toggle on event");
    chk_pulse_holds: assert property (!evFire |=> $stable(alarmPulse_r)) // [R17]
        else $error("alarm pulse changed without event");
    chk_no_fire_disabled: assert property (!enable_r |-> !evFire) // [R4]
        else $error("alarm fired while disabled");
    chk_once_per_update: assert property (evFire |-> cen && digitUpdate && match) // [R18]
        else $error("alarm fired outside a digit update");
    chk_rpt_decrement: assert property (evFire && !wrCfg && rpt_r != 8'h00
                                        |=> rpt_r == $past(rpt_r) - 8'h01 && enable_r) // [R9]
        else $error("repeat counter not decremented");
    chk_last_alarm_off: assert property (evFire && !wrCfg && rpt_r == 8'h00 && !endless_repeat_flag_r
                                         |=> !enable_r ##1 !evFire) // [R10]
        else $error("alarm not disabled after last event");
    chk_endless_repeat_flag_wraps: assert property (evFire && !wrCfg && rpt_r == 8'h00 && endless_repeat_flag_r
                                      |=> rpt_r == 8'hff && enable_r) // [R11]
        else $error("endless_repeat_flag did not wrap repeat counter");
    chk_cal_quarter: assert property (calFire |=> calValid_r && calAmount_r == {$past(cal_r), 2'b00}) // [R2]
        else $error("calibration adjust missing or wrong");
    chk_cal_unsafe_flag: assert property (cen && wrCal && timerOn && isQuarter(curSeconds)
                                          |=> flags_r[ST_CAL_UNSAFE]) // [R1]
        else $error("unsafe calibration write not flagged");
    chk_bvalid_holds: assert property (bValid_r && !s_axi_bready |=> bValid_r)
        else $error("write response dropped before bready");

    cov_alarm_event: cover property (evFire);
    cov_endless_repeat_flag_wrap: cover property (evFire && rpt_r == 8'h00 && endless_repeat_flag_r);
    cov_auto_disable: cover property (evFire && rpt_r == 8'h00 && !endless_repeat_flag_r);
    cov_cal_adjust: cover property (calFire);
endmodule
`default_nettype wire

// >>> design/rtcar_pkg.sv
// constants shared by the alarm, repeat and calibration-window block
package rtcar_pkg;

    localparam int          DATA_W          = 32;

    // register byte offsets
    localparam logic [7:0]  OFF_CLOCK_CAL   = 8'h00;
    localparam logic [7:0]  OFF_ALARM_CFG   = 8'h04;
    localparam logic [7:0]  OFF_ALARM_TIME  = 8'h08;
    localparam logic [7:0]  OFF_ALARM_DATE  = 8'h0c;
    localparam logic [7:0]  OFF_STATUS      = 8'h10;

    // alarm_config_repeat field positions
    localparam int          CFG_EN_BIT      = 15;
    localparam int          CFG_ENDLESS_REPEAT_FLAG_BIT   = 14;
    localparam int          CFG_MASK_HI     = 13;
    localparam int          CFG_MASK_LO     = 10;
    localparam int          CFG_RPT_HI      = 7;
    localparam int          CFG_RPT_LO      = 0;

    // status register field positions
    localparam int          ST_CAL_UNSAFE   = 0;
    localparam int          ST_CMP_UNSAFE   = 1;
    localparam int          ST_CFG_UNSAFE   = 2;
    localparam int          ST_NUM_FLAGS    = 3;
    localparam int          ST_ENABLE_BIT   = 8;
    localparam int          ST_PULSE_BIT    = 9;
    localparam int          ST_SYNC_BIT     = 10;
    localparam int          ST_TIMER_BIT    = 11;
    localparam int          ST_RPT_LO       = 16;

    // values after reset, and the value the repeat counter wraps to
    localparam logic [7:0]  RST_CAL         = 8'h00;
    localparam logic [7:0]  RST_RPT         = 8'h00;
    localparam logic [3:0]  RST_MASK        = 4'h0;
    localparam logic [7:0]  RST_DIGIT       = 8'h00;
    localparam logic [7:0]  RPT_WRAP        = 8'hff;

    // digit-mask codes: interval between alarms
    localparam logic [3:0]  MASK_HALF_SEC   = 4'h0;
    localparam logic [3:0]  MASK_SECOND     = 4'h1;
    localparam logic [3:0]  MASK_TEN_SEC    = 4'h2;
    localparam logic [3:0]  MASK_MINUTE     = 4'h3;
    localparam logic [3:0]  MASK_TEN_MIN    = 4'h4;
    localparam logic [3:0]  MASK_HOUR       = 4'h5;
    localparam logic [3:0]  MASK_DAY        = 4'h6;
    localparam logic [3:0]  MASK_WEEK       = 4'h7;
    localparam logic [3:0]  MASK_MONTH      = 4'h8;
    localparam logic [3:0]  MASK_YEAR       = 4'h9;

    // quarter-minute seconds counts (bcd) at which calibration is applied
    localparam logic [7:0]  SEC_Q0          = 8'h00;
    localparam logic [7:0]  SEC_Q1          = 8'h15;
    localparam logic [7:0]  SEC_Q2          = 8'h30;
    localparam logic [7:0]  SEC_Q3          = 8'h45;

    // axi responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

// >>> design/rtcar_match.sv
// masked comparison of alarm digits against clock digits
`timescale 1ns/1ps
`default_nettype none
module rtcar_match
    import rtcar_pkg::*;
(
    input  wire logic [3:0] mask,
    input  wire logic       curHalfSec,
    input  wire logic [7:0] curSeconds,
    input  wire logic [7:0] curMinutes,
    input  wire logic [7:0] curHours,
    input  wire logic [2:0] curWeekday,
    input  wire logic [7:0] curDay,
    input  wire logic [7:0] curMonth,
    input  wire logic [7:0] almSeconds,
    input  wire logic [7:0] almMinutes,
    input  wire logic [7:0] almHours,
    input  wire logic [2:0] almWeekday,
    input  wire logic [7:0] almDay,
    input  wire logic [7:0] almMonth,
    output logic            match
);
    logic eqSecU;
    logic eqSec;
    logic eqMinU;
    logic eqMin;
    logic eqHour;
    logic eqWday;
    logic eqDay;
    logic eqMonth;
    logic wholeSec;

    assign eqSecU   = curSeconds[3:0] == almSeconds[3:0];
    assign eqSec    = curSeconds == almSeconds;
    assign eqMinU   = curMinutes[3:0] == almMinutes[3:0];
    assign eqMin    = curMinutes == almMinutes;
    assign eqHour   = curHours == almHours;
    assign eqWday   = curWeekday == almWeekday;
    assign eqDay    = curDay == almDay;
    assign eqMonth  = curMonth == almMonth;
    // coarser intervals fire on the whole-second update only
    assign wholeSec = !curHalfSec;

    // each mask code selects the digits that must agree [R3] [R6]
    always_comb begin
        case (mask)
            MASK_HALF_SEC: match = 1'b1;
            MASK_SECOND:   match = wholeSec;
            MASK_TEN_SEC:  match = wholeSec && eqSecU;
            MASK_MINUTE:   match = wholeSec && eqSec;
            MASK_TEN_MIN:  match = wholeSec && eqSec && eqMinU;
            MASK_HOUR:     match = wholeSec && eqSec && eqMin;
            MASK_DAY:      match = wholeSec && eqSec && eqMin && eqHour;
            MASK_WEEK:     match = wholeSec && eqSec && eqMin && eqHour && eqWday;
            MASK_MONTH:    match = wholeSec && eqSec && eqMin && eqHour && eqDay;
            MASK_YEAR:     match = wholeSec && eqSec && eqMin && eqHour && eqDay && eqMonth;
            // reserved codes never match
            default:       match = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// >>> sim/rtcar_top_tb.sv
// self-checking bench for the alarm, repeat and calibration block
`timescale 1ns/1ps
`default_nettype none
module rtcar_top_tb;
    import rtcar_pkg::*;
    logic clk = 0, resetn = 0, cen = 1, du = 0, timerOn = 0, syncSt = 0, half = 0;
    logic [7:0] sec = 0, dig = 0, awaddr = 0, araddr = 0;
    logic [2:0] wday = 0;
    logic [31:0] wdata = 0, rdat, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq, pulse, calValid;
    logic [1:0] bresp, rresp, resp;
    logic [9:0] calAmt;
    int err_total = 0, tests_run = 0;
    always #20 clk = ~clk;
    rtcar_top i_dut (.clk(clk), .resetn(resetn), .cen(cen), .digitUpdate(du), .timerOn(timerOn),
        .clockSyncStatus(syncSt), .curHalfSec(half), .curSeconds(sec), .curMinutes(dig), .curHours(dig),
        .curWeekday(wday), .curDay(dig), .curMonth(dig), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .alarmIrq(irq),
        .alarmPulse(pulse), .calAdjustValid(calValid), .calAdjustAmount(calAmt));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        ta = 0;
        tw = 0;
        tb = 0;
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!tb) begin
            @(posedge clk);
            if (!ta && awready) begin ta = 1; awvalid <= 0; end
            if (!tw && wready) begin tw = 1; wvalid <= 0; end
            if (ta && tw && bvalid) begin tb = 1; resp = bresp; bready <= 0; end
        end
    endtask
    // loop on a local flag: rready itself only changes after the edge
    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        ta = 0;
        tr = 0;
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        while (!tr) begin
            @(posedge clk);
            if (!ta && arready) begin ta = 1; arvalid <= 0; end
            if (ta && rvalid) begin tr = 1; rdat = rdata; resp = rresp; rready <= 0; end
        end
    endtask
    // one digit update; returns just after the edge that samples it
    task automatic evt(input logic [7:0] s, input logic h);
        @(posedge clk);
        sec <= s; half <= h; du <= 1;
        @(posedge clk);
        du <= 0;
        #1;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // generous bound: the whole sequence needs well under 400 cycles
    initial begin
        #(40 * 5000);
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1;
        rd(OFF_ALARM_CFG); chk(rdat, 32'h0);
        rd(8'h14); chk(resp, RESP_SLVERR);
        $display("test registers done");
        wr(OFF_ALARM_CFG, 32'h8401);
        evt(8'h05, 1); chk(irq, 1'b0);
        evt(8'h05, 0); chk({irq, pulse}, 2'b11);
        #40; chk(irq, 1'b0);
        rd(OFF_ALARM_CFG); chk(rdat, 32'h8400);
        evt(8'h06, 0); chk({irq, pulse}, 2'b10);
        rd(OFF_ALARM_CFG); chk(rdat, 32'h0400);
        evt(8'h07, 0); chk(irq, 1'b0);
        $display("test repeat done");
        wr(OFF_ALARM_CFG, 32'hc400);
        evt(8'h08, 0); chk(irq, 1'b1);
        rd(OFF_ALARM_CFG); chk(rdat, 32'hc4ff);
        evt(8'h09, 0); chk(irq, 1'b1);
        rd(OFF_ALARM_CFG); chk(rdat, 32'hc4fe);
        wr(OFF_ALARM_CFG, 32'h0);
        $display("test endless_repeat_flag done");
        wr(OFF_CLOCK_CAL, 32'h85);
        timerOn <= 1;
        evt(8'h15, 0); chk({calValid, calAmt}, {1'b1, 10'h214});
        evt(8'h16, 0); chk(calValid, 1'b0);
        evt(8'h45, 1); chk(calValid, 1'b0);
        $display("test calibration done");
        wr(OFF_ALARM_TIME, 32'h30);
        wr(OFF_ALARM_CFG, 32'h8c00);
        evt(8'h29, 0); chk(irq, 1'b0);
        evt(8'h30, 0); chk({irq, pulse}, 2'b11);
        rd(OFF_STATUS); chk(rdat, 32'h00000a00);
        $display("test mask done");
        syncSt <= 1;
        wr(OFF_ALARM_CFG, 32'h8c00);
        wr(OFF_ALARM_TIME, 32'h30);
        wr(OFF_CLOCK_CAL, 32'h85);
        rd(OFF_STATUS); chk(rdat, 32'h00000f07);
        wr(OFF_STATUS, 32'h7); chk(resp, RESP_OKAY);
        rd(OFF_STATUS); chk(rdat, 32'h00000f00);
        $display("test flags done");
        end_of_test();
    end
endmodule
`default_nettype wire
